/* zq_odt_vref_map.svh */
`ifndef ZQ_ODT_VREF_MAP_SVH
`define ZQ_ODT_VREF_MAP_SVH
// ==========================================
// mode addresses
`define MA_CAL_RESET   6'h0a
`define MA_TERM        6'h0b
`define MA_CA_REF      6'h0c
// ==========================================
// field positions
`define CAL_REQ_BIT    0
`define DQ_ODT_LSB     0
`define CA_ODT_LSB     4
`define REF_LEVEL_LSB  0
`define REF_RANGE_BIT  6
`define TRAIN_MODE_BIT 7
// ==========================================
// reset values
`define ODT_RST        3'h0
`define REF_LEVEL_RST  6'h00
`define REF_RANGE_RST  1'h1
`define TRAIN_MODE_RST 1'h0
// ==========================================
// odt codes and level mapping, level in 0.001 percent
`define ODT_OFF        3'h0
`define ODT_RSVD       3'h7
`define REF_LEVEL_MAX  6'h32
`define R0_BASE        16'h3a98
`define R0_STEP        16'h0256
`define R1_BASE        16'h8084
`define R1_STEP        16'h0258
`endif

/* zq_odt_vref_pkg.sv */
`default_nettype none
package zq_odt_vref_pkg;
  // ==========================================
  // mode register command
  typedef struct packed {
    logic       write;
    logic [5:0] addr;
    logic [7:0] data;
  } mr_cmd_t;
  // ==========================================
  // one set point copy
  typedef struct packed {
    logic [2:0] dq_odt;
    logic [2:0] ca_odt;
    logic [5:0] level;
    logic       range;
    logic       cbt;
  } ref_cfg_t;
endpackage : zq_odt_vref_pkg
`default_nettype wire

/* zq_odt_vref_regs.sv */
// Contract
// - address 0x0a bit 0 requests default calibration, other bits reserved
// - calibration pin grounded means calibration commands are ignored
// - calibration pin on resistor allows full or default calibration
// - address 0x0b is write only, data odt bits 2:0, ca odt 6:4
// - data odt code 0 off, 1 to 6 resistor divisor, 7 reserved
// - ca odt code uses the same scheme as data odt
// - two copies per bit, writes go to the write-select copy
// - reads of 0x0c return the write-select copy
// - behaviour follows only the operate-select copy
// - writing the inactive copy never disturbs operation
// - address 0x0c holds level 5:0, range bit 6, training bit 7
// - level codes 0 to 50 valid; controller writes only those
// - level maps linearly to percent of supply per range
// - range bit clear is range 0, set is range 1, default 1
// - range is kept until overwritten or reset
// - training bit clear mode 1, set mode 2, only in x8
// - reads put bits 7:0 on data 7:0, others zero
`timescale 1ns/1ps
`default_nettype none
`include "zq_odt_vref_map.svh"
module zq_odt_vref_regs (
  // reference domain
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  // link domain
  input  wire logic                       i_dram_clk,
  input  wire logic                       i_cmd_valid,
  input  wire zq_odt_vref_pkg::mr_cmd_t   i_cmd,
  input  wire logic                       i_cal_cmd,
  input  wire logic                       i_setpoint_write_select,
  input  wire logic                       i_setpoint_operate_select,
  output logic                            o_mrr_valid,
  output logic [7:0]                      o_mrr_data,
  // straps
  input  wire logic                       i_cal_pin_resistor,
  input  wire logic                       i_byte_mode,
  // analog controls
  output logic [2:0]                      o_dq_odt_code,
  output logic                            o_dq_odt_en,
  output logic [2:0]                      o_ca_odt_code,
  output logic                            o_ca_odt_en,
  output logic [5:0]                      o_vref_code,
  output logic                            o_vref_range,
  output logic [15:0]                     o_vref_level,
  output logic                            o_cbt_mode2,
  output logic                            o_cal_default_start,
  output logic                            o_cal_full_start
);
  import zq_odt_vref_pkg::*;

  // ==========================================
  // decode
  function automatic logic odt_on(input logic [2:0] code);
    odt_on = (code != `ODT_OFF) && (code != `ODT_RSVD);
  endfunction : odt_on

  localparam ref_cfg_t CFG_RST = '{dq_odt: `ODT_RST, ca_odt: `ODT_RST,
    level: `REF_LEVEL_RST, range: `REF_RANGE_RST, cbt: `TRAIN_MODE_RST};

  // ==========================================
  // link domain
  logic       lrst_meta_ff;
  logic       lrst_ff;
  ref_cfg_t   copy_ff [2];
  ref_cfg_t   snap_ff;
  logic       req_tgl_ff;
  logic       ack_meta_ff;
  logic       ack_sync_ff;
  logic       cal_def_tgl_ff;
  logic       cal_cmd_tgl_ff;
  logic       mrr_valid_ff;
  logic [7:0] mrr_data_ff;

  wire ref_cfg_t wr_copy = copy_ff[i_setpoint_write_select];
  wire ref_cfg_t active  = copy_ff[i_setpoint_operate_select];
  wire wr_en  = i_cmd_valid && i_cmd.write;
  wire rd_en  = i_cmd_valid && !i_cmd.write;
  wire wr_cal  = wr_en && (i_cmd.addr == `MA_CAL_RESET);
  wire wr_term = wr_en && (i_cmd.addr == `MA_TERM);
  wire wr_ref  = wr_en && (i_cmd.addr == `MA_CA_REF);
  wire rd_ref  = rd_en && (i_cmd.addr == `MA_CA_REF);
  wire busy    = req_tgl_ff != ack_sync_ff;
  wire [7:0] rd_word = {wr_copy.cbt, wr_copy.range, wr_copy.level};

  // reset reaches the link domain through two flops
  always_ff @(posedge i_dram_clk) begin
    lrst_meta_ff <= i_rst;
    lrst_ff      <= lrst_meta_ff;
  end

  always_ff @(posedge i_dram_clk) begin
    for (int s = 0; s < 2; s++) begin
      if (lrst_ff) begin
        copy_ff[s] <= CFG_RST;
      end else if (i_setpoint_write_select == s[0]) begin
        if (wr_term) begin
          copy_ff[s].dq_odt <= i_cmd.data[`DQ_ODT_LSB +: 3];
          copy_ff[s].ca_odt <= i_cmd.data[`CA_ODT_LSB +: 3];
        end
        if (wr_ref) begin
          copy_ff[s].level <= i_cmd.data[`REF_LEVEL_LSB +: 6];
          copy_ff[s].range <= i_cmd.data[`REF_RANGE_BIT];
          copy_ff[s].cbt   <= i_cmd.data[`TRAIN_MODE_BIT];
        end
      end
    end
  end

  always_ff @(posedge i_dram_clk) begin
    if (lrst_ff) begin
      mrr_valid_ff <= 1'b0;
      mrr_data_ff  <= 8'h00;
    end else begin
      mrr_valid_ff <= rd_en;
      mrr_data_ff  <= rd_ref ? rd_word : 8'h00;
    end
  end

  always_ff @(posedge i_dram_clk) begin
    if (lrst_ff) begin
      snap_ff    <= CFG_RST;
      req_tgl_ff <= 1'b0;
    end else if (!busy && (active != snap_ff)) begin
      snap_ff    <= active;
      req_tgl_ff <= !req_tgl_ff;
    end
  end

  // each request is one toggle, nothing to clear
  always_ff @(posedge i_dram_clk) begin
    if (lrst_ff) begin
      cal_def_tgl_ff <= 1'b0;
      cal_cmd_tgl_ff <= 1'b0;
    end else begin
      if (wr_cal && i_cmd.data[`CAL_REQ_BIT]) begin
        cal_def_tgl_ff <= !cal_def_tgl_ff;
      end
      if (i_cal_cmd) begin
        cal_cmd_tgl_ff <= !cal_cmd_tgl_ff;
      end
    end
  end

  assign o_mrr_valid = mrr_valid_ff;
  assign o_mrr_data  = mrr_data_ff;

  // ==========================================
  // reference domain
  logic       ack_tgl_ff;
  logic       req_meta_ff;
  logic       req_sync_ff;
  logic       cd_meta_ff;
  logic       cd_sync_ff;
  logic       cd_seen_ff;
  logic       cf_meta_ff;
  logic       cf_sync_ff;
  logic       cf_seen_ff;
  logic       cpin_meta_ff;
  logic       cpin_ff;
  logic       x8_meta_ff;
  logic       x8_ff;
  ref_cfg_t   cfg_ff;
  logic       cal_def_ff;
  logic       cal_full_ff;
  logic [15:0] level_ff;
  logic       cbt2_ff;
  logic [2:0] dq_code_ff;
  logic [2:0] ca_code_ff;
  logic       dq_en_ff;
  logic       ca_en_ff;

  // acknowledge returns to the link side through two flops
  always_ff @(posedge i_dram_clk) begin
    ack_meta_ff <= ack_tgl_ff;
    ack_sync_ff <= ack_meta_ff;
  end

  always_ff @(posedge i_ref_clk) begin
    req_meta_ff  <= req_tgl_ff;
    req_sync_ff  <= req_meta_ff;
    cd_meta_ff   <= cal_def_tgl_ff;
    cd_sync_ff   <= cd_meta_ff;
    cf_meta_ff   <= cal_cmd_tgl_ff;
    cf_sync_ff   <= cf_meta_ff;
    cpin_meta_ff <= i_cal_pin_resistor;
    cpin_ff      <= cpin_meta_ff;
    x8_meta_ff   <= i_byte_mode;
    x8_ff        <= x8_meta_ff;
  end

  wire new_cfg  = req_sync_ff != ack_tgl_ff;
  wire cd_event = cd_sync_ff != cd_seen_ff;
  wire cf_event = cf_sync_ff != cf_seen_ff;
  wire [15:0] base = cfg_ff.range ? `R1_BASE : `R0_BASE;
  wire [15:0] step = cfg_ff.range ? `R1_STEP : `R0_STEP;
  wire [15:0] level_w = base + 16'(16'(cfg_ff.level) * step);

  // snapshot is held stable while the toggles differ
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_ff     <= CFG_RST;
      ack_tgl_ff <= 1'b0;
    end else if (new_cfg) begin
      cfg_ff     <= snap_ff;
      ack_tgl_ff <= req_sync_ff;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cd_seen_ff  <= 1'b0;
      cf_seen_ff  <= 1'b0;
      cal_def_ff  <= 1'b0;
      cal_full_ff <= 1'b0;
    end else begin
      cd_seen_ff  <= cd_sync_ff;
      cf_seen_ff  <= cf_sync_ff;
      // default request honoured with either strap
      cal_def_ff  <= cd_event;
      cal_full_ff <= cf_event && cpin_ff;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dq_code_ff <= `ODT_RST;
      ca_code_ff <= `ODT_RST;
      dq_en_ff   <= 1'b0;
      ca_en_ff   <= 1'b0;
      level_ff   <= `R1_BASE;
      cbt2_ff    <= 1'b0;
    end else begin
      dq_code_ff <= cfg_ff.dq_odt;
      ca_code_ff <= cfg_ff.ca_odt;
      dq_en_ff   <= odt_on(cfg_ff.dq_odt);
      ca_en_ff   <= odt_on(cfg_ff.ca_odt);
      level_ff   <= level_w;
      // mode 2 only for x8 parts
      cbt2_ff    <= cfg_ff.cbt && x8_ff;
    end
  end

  // range output straight from cfg_ff, the handed-over snapshot of the active copy
  assign o_vref_range        = cfg_ff.range;
  assign o_vref_code         = cfg_ff.level;
  assign o_vref_level        = level_ff;
  assign o_dq_odt_code       = dq_code_ff;
  assign o_ca_odt_code       = ca_code_ff;
  assign o_dq_odt_en         = dq_en_ff;
  assign o_ca_odt_en         = ca_en_ff;
  assign o_cbt_mode2         = cbt2_ff;
  assign o_cal_default_start = cal_def_ff;
  assign o_cal_full_start    = cal_full_ff;

  // ==========================================
  // checks
  sequence cfg_req_s;
    req_sync_ff != ack_tgl_ff;
  endsequence
  sequence cfg_take_s;
    ##1 (cfg_ff == $past(snap_ff));
  endsequence

  cfg_update_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cfg_req_s |-> cfg_take_s)
    else $error("active copy not taken");
  cal_ground_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cal_full_start |-> $past(cpin_ff))
    else $error("calibration started with grounded pin");
  cal_oneshot_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    (wr_cal && i_cmd.data[`CAL_REQ_BIT]) |=> (cal_def_tgl_ff != $past(cal_def_tgl_ff)))
    else $error("calibration request lost");
  copy_select_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    (wr_term || wr_ref) && !i_setpoint_write_select |=> $stable(copy_ff[1]))
    else $error("wrong set point copy written");
  mrr_copy_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    rd_ref |=> o_mrr_valid && (o_mrr_data == $past(rd_word)))
    else $error("read did not return write-select copy");
  mrr_zero_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    (rd_en && !rd_ref) |=> (o_mrr_data == 8'h00))
    else $error("unmapped read not zero");
  inactive_hold_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    ((wr_term || wr_ref) && (i_setpoint_write_select != i_setpoint_operate_select))
    ##1 $stable(i_setpoint_operate_select) |-> $stable(active))
    else $error("inactive write disturbed active copy");
  range_keep_a: assert property (@(posedge i_dram_clk) disable iff (lrst_ff)
    !wr_ref |=> $stable(copy_ff[0].range) && $stable(copy_ff[1].range))
    else $error("range changed without a write");
  dq_odt_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_dq_odt_en |-> (o_dq_odt_code != `ODT_OFF) && (o_dq_odt_code != `ODT_RSVD))
    else $error("data odt enabled on off code");
  ca_odt_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ca_code_ff inside {[3'h1:3'h6]}) |-> o_ca_odt_en)
    else $error("ca odt not enabled");
  cbt_x8_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_cbt_mode2 |-> $past(x8_ff) && $past(cfg_ff.cbt))
    else $error("training mode 2 outside x8");
  level_map_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $stable(cfg_ff) && cfg_ff.range && (cfg_ff.level == `REF_LEVEL_MAX)
    |=> (o_vref_level == 16'hf5b4))
    else $error("range 1 top level wrong");
endmodule : zq_odt_vref_regs
`default_nettype wire

/* mr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mr_ctrl_model (
  // link side
  input  wire logic                    i_clk,
  input  wire logic                    i_mrr_valid,
  input  wire logic [7:0]              i_mrr_data,
  // commands
  output logic                         o_cmd_valid,
  output var zq_odt_vref_pkg::mr_cmd_t o_cmd,
  output logic                         o_cal_cmd,
  output logic                         o_wsel,
  output logic                         o_osel
);
  import zq_odt_vref_pkg::*;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
    o_cal_cmd   = 1'b0;
    o_wsel      = 1'b0;
    o_osel      = 1'b0;
  end
  // ==========================================
  // bus cycles
  task automatic send(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd       <= {w, a, d};
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // released bus shows the inverse so a stale command never looks fresh
    o_cmd       <= ~{w, a, d};
  endtask : send
  // whole byte, level and range together
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    send(1'b1, a, d);
  endtask : mrw
  task automatic mrr(input logic [5:0] a, output logic [7:0] d);
    d = 8'hxx;
    send(1'b0, a, 8'h00);
    for (int i = 0; i < 3; i++) begin
      #1;
      if (i_mrr_valid === 1'b1) begin
        d = i_mrr_data;
        break;
      end
      @(posedge i_clk);
    end
  endtask : mrr
  task automatic sel(input logic w, input logic o);
    @(posedge i_clk);
    o_wsel <= w;
    o_osel <= o;
  endtask : sel
  task automatic cal();
    @(posedge i_clk);
    o_cal_cmd <= 1'b1;
    @(posedge i_clk);
    o_cal_cmd <= 1'b0;
  endtask : cal
endmodule : mr_ctrl_model
`default_nettype wire

/* dram_zq_odt_vref_mode_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dram_zq_odt_vref_mode_regs_tb_top;
  import zq_odt_vref_pkg::*;
  logic ref_clk = 0, dram_clk = 0, rst = 1, pin_res = 1, byte_mode = 0;
  logic cmd_valid, cal_cmd, wsel, osel, mrr_valid, c_def, c_full, dqe, cae, rng, cbt2;
  mr_cmd_t cmd;
  logic [7:0] mrr_data;
  logic [2:0] dqc, cac;
  logic [5:0] vcode;
  logic [15:0] vlvl;
  int num_errors = 0, n_checks = 0, n_def = 0, n_full = 0, cyc = 0, b0, b1;
  wire [15:0] st = {dqc, dqe, cac, cae, vcode, rng, cbt2};
  always #50 ref_clk = ~ref_clk;
  always #80 dram_clk = ~dram_clk;
  mr_ctrl_model u_ctrl (.i_clk(dram_clk), .i_mrr_valid(mrr_valid), .i_mrr_data(mrr_data),
    .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_cal_cmd(cal_cmd), .o_wsel(wsel), .o_osel(osel));
  zq_odt_vref_regs u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_dram_clk(dram_clk),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cal_cmd(cal_cmd),
    .i_setpoint_write_select(wsel), .i_setpoint_operate_select(osel),
    .o_mrr_valid(mrr_valid), .o_mrr_data(mrr_data), .i_cal_pin_resistor(pin_res),
    .i_byte_mode(byte_mode), .o_dq_odt_code(dqc), .o_dq_odt_en(dqe), .o_ca_odt_code(cac),
    .o_ca_odt_en(cae), .o_vref_code(vcode), .o_vref_range(rng), .o_vref_level(vlvl),
    .o_cbt_mode2(cbt2), .o_cal_default_start(c_def), .o_cal_full_start(c_full));
  // ==========================================
  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (c_def === 1'b1) n_def <= n_def + 1;
    if (c_full === 1'b1) n_full <= n_full + 1;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bound from the hand-over: 3 link plus 7 reference cycles
  task automatic settle();
    repeat (3) @(posedge dram_clk);
    repeat (7) @(posedge ref_clk);
  endtask : settle
  task automatic look(input logic [2:0] dq, input logic [2:0] ca, input logic [5:0] lv,
                      input logic rg, input logic cb);
    logic [15:0] lvl;
    settle();
    lvl = rg ? 16'h8084 + 16'h0258 * lv : 16'h3a98 + 16'h0256 * lv;
    chk(st, {dq, dq inside {[3'h1:3'h6]}, ca, ca inside {[3'h1:3'h6]}, lv, rg, cb & byte_mode});
    chk(vlvl, lvl);
  endtask : look
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_ctrl.mrr(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rd
  task automatic do_rst();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge dram_clk);
  endtask : do_rst
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ==========================================
  // tests
  initial begin
    do_rst();
    look(3'h0, 3'h0, 6'h00, 1'b1, 1'b0);
    rd(6'h0c, 8'h40);
    rd(6'h0b, 8'h00);
    rd(6'h0a, 8'h00);
    rd(6'h20, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      u_ctrl.mrw(6'h0b, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
      look(3'(c), 3'(7 - c), 6'h00, 1'b1, 1'b0);
    end
    u_ctrl.mrw(6'h20, 8'hff);
    look(3'h7, 3'h0, 6'h00, 1'b1, 1'b0);
    $display("test termination done");
    u_ctrl.sel(1'b1, 1'b0);
    u_ctrl.mrw(6'h0c, 8'hb2);
    look(3'h7, 3'h0, 6'h00, 1'b1, 1'b0);
    rd(6'h0c, 8'hb2);
    u_ctrl.sel(1'b0, 1'b1);
    rd(6'h0c, 8'h40);
    look(3'h0, 3'h0, 6'h32, 1'b0, 1'b1);
    @(posedge ref_clk);
    byte_mode <= 1'b1;
    look(3'h0, 3'h0, 6'h32, 1'b0, 1'b1);
    u_ctrl.sel(1'b1, 1'b1);
    u_ctrl.mrw(6'h0c, 8'h72);
    look(3'h0, 3'h0, 6'h32, 1'b1, 1'b0);
    u_ctrl.mrw(6'h0b, 8'h21);
    look(3'h1, 3'h2, 6'h32, 1'b1, 1'b0);
    u_ctrl.sel(1'b0, 1'b0);
    look(3'h7, 3'h0, 6'h00, 1'b1, 1'b0);
    $display("test setpoint done");
    b0 = n_def;
    b1 = n_full;
    u_ctrl.mrw(6'h0a, 8'h01);
    u_ctrl.mrw(6'h0a, 8'h01);
    u_ctrl.mrw(6'h0a, 8'hfe);
    u_ctrl.cal();
    settle();
    chk(16'(n_def - b0), 16'h0002);
    chk(16'(n_full - b1), 16'h0001);
    @(posedge ref_clk);
    pin_res <= 1'b0;
    settle();
    u_ctrl.cal();
    u_ctrl.mrw(6'h0a, 8'h01);
    settle();
    chk(16'(n_full - b1), 16'h0001);
    chk(16'(n_def - b0), 16'h0003);
    $display("test calibration done");
    do_rst();
    look(3'h0, 3'h0, 6'h00, 1'b1, 1'b0);
    rd(6'h0c, 8'h40);
    $display("test second reset done");
    test_done();
  end
endmodule : dram_zq_odt_vref_mode_regs_tb_top
`default_nettype wire
